// file: src/fmc_params.svh
`ifndef FMC_PARAMS_SVH
`define FMC_PARAMS_SVH
// register indices; byte address is four times the index
`define FMC_IDX_CFG      6'h01
`define FMC_IDX_FANS     6'h03
`define FMC_IDX_PINSEL   6'h05
`define FMC_IDX_ALARM    6'h07
`define FMC_IDX_HOTPLUG  6'h08
`define FMC_ADDR_W       8
// global_config fields
`define FMC_CFG_INSTALL  0
`define FMC_CFG_MASK     1
`define FMC_CFG_ARA_DIS  2
`define FMC_CFG_FWTEST   3
`define FMC_CFG_START    4
`define FMC_CFG_FCFAULT  5
`define FMC_CFG_FALERT   6
`define FMC_CFG_POL      7
// reset values before the straps are loaded
`define FMC_RST_CFG      7'h00
`define FMC_RST_FANS     2'h1
`define FMC_RST_PINSEL   7'h7f
`define FMC_RST_FORCE    2'h0
// timing
`define FMC_CLK_HZ       100000000
`define FMC_FW_TEST_S    10
`endif

// file: src/fmc_pkg.sv
`include "fmc_params.svh"
package fmc_pkg;
    typedef struct packed {
        logic                    read;
        logic                    write;
        logic [`FMC_ADDR_W-1:0]  address;
        logic [31:0]             writedata;
        logic [3:0]              byteenable;
    } fmc_av_req_t;
    typedef struct packed {
        logic [1:0] alarm;
        logic [1:0] hotplug;
    } fmc_fan_t;
    typedef enum logic [1:0] {
        FMC_SYNC,
        FMC_LOAD,
        FMC_RUN
    } fmc_state_t;
endpackage

// file: src/fmc_config_regs.sv
`timescale 1ns/1ns
`include "fmc_params.svh"
// What this block does
// - config bit 0 and fans-in-system bit 1 are one stored bit.
// - config bit 1 set masks the alert output for all sources.
// - config bit 2 set stops alert response address participation.
// - writing config bit 3 starts free-wheel test, pausing monitoring.
// - free-wheel bit clears itself when the ten-second test ends.
// - config bit 4 set starts the round-robin monitoring cycle.
// - monitoring-start bit zero drives both fans at alarm speed.
// - monitoring-start bit powers up from the install strap pin.
// - config bit 5 forces cascade fault output low.
// - config bit 6 forces alert output asserted at chosen level.
// - config bit 7 picks alert level, 1 high, 0 low, resets low.
// - pin-select bits 0,1 power up 1; zero selects analog inputs.
// - pin-select bit 2 powers up 1 and stays writable.
// - pin-select bits 3,4 zero when first diode detected, writable.
// - pin-select bits 5,6 zero when second diode detected, writable.
// - reserved bits are read-only and read zero.
// - alarm-force bits make fan 1 or 2 run at alarm speed.
// - hot-plug-force bits make fan 1 or 2 run at hot-plug speed.
// - fan-2-installed bit loads from install strap, then writable.
module fmc_config_regs #(
    parameter int unsigned N_IRQ          = 4,
    parameter int unsigned FW_TEST_CYCLES = `FMC_FW_TEST_S * `FMC_CLK_HZ
) (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire fmc_pkg::fmc_av_req_t av_req,
    output logic [31:0]               av_readdata,
    output logic                      av_waitrequest,
    input  wire logic                 install_strap_pin,
    input  wire logic                 remote_diode_one,
    input  wire logic                 remote_diode_two,
    input  wire logic [N_IRQ-1:0]     irq_source,
    input  wire logic                 fault_active,
    output logic                      alert_pin,
    output logic                      cascade_fault_n,
    output logic                      ara_respond_en,
    output logic                      monitor_run,
    output logic                      fw_test_run,
    output fmc_pkg::fmc_fan_t         fan_force,
    output logic [6:0]                pin_select
);

    logic [2:0]              strap_s1;
    logic [2:0]              strap_s2;
    fmc_pkg::fmc_state_t     state;
    logic                    ack;
    logic [7:1]              cfg;
    logic [1:0]              fans;
    logic [6:0]              pinsel;
    logic [1:0]              alarm_force;
    logic [1:0]              hotplug_force;
    logic [31:0]             fw_cnt;
    logic                    fw_done;
    logic                    wr_hit;
    logic [5:0]              idx;
    logic [7:0]              wbyte;
    logic [7:0]              rd_value;
    logic                    alert_on;

    // strap and diode-detect pins come from outside the clock domain; no reset here,
    // so the pair has settled on the pin levels by the time the load state reads it
    always_ff @(posedge clk) begin
        strap_s1 <= {remote_diode_two, remote_diode_one, install_strap_pin};
        strap_s2 <= strap_s1;
    end

    // straps are caught after release, once the synchroniser has settled
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= fmc_pkg::FMC_SYNC;
        end else begin
            case (state)
                fmc_pkg::FMC_SYNC: state <= fmc_pkg::FMC_LOAD;
                fmc_pkg::FMC_LOAD: state <= fmc_pkg::FMC_RUN;
                fmc_pkg::FMC_RUN:  state <= fmc_pkg::FMC_RUN;
                default:           state <= fmc_pkg::FMC_SYNC;
            endcase
        end
    end

    // one wait state per access; bus held off until straps are loaded
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack <= 1'b0;
        end else begin
            ack <= (av_req.read | av_req.write) & ~ack & (state == fmc_pkg::FMC_RUN);
        end
    end

    assign av_waitrequest = ~ack;
    assign idx            = av_req.address[7:2];
    assign wr_hit         = ack & av_req.write & av_req.byteenable[0] & (av_req.address[1:0] == 2'h0);
    assign wbyte          = av_req.writedata[7:0];
    assign fw_done        = cfg[`FMC_CFG_FWTEST] && (fw_cnt == FW_TEST_CYCLES - 1);

    // global_config, bits 1..7; bit 0 lives in fans
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg <= `FMC_RST_CFG;
        end else if (state == fmc_pkg::FMC_LOAD) begin
            cfg[`FMC_CFG_START] <= strap_s2[0];
        end else begin
            if (fw_done) begin
                cfg[`FMC_CFG_FWTEST] <= 1'b0;
            end
            if (wr_hit && idx == `FMC_IDX_CFG) begin
                cfg[`FMC_CFG_MASK]    <= wbyte[`FMC_CFG_MASK];
                cfg[`FMC_CFG_ARA_DIS] <= wbyte[`FMC_CFG_ARA_DIS];
                cfg[`FMC_CFG_START]   <= wbyte[`FMC_CFG_START];
                cfg[`FMC_CFG_FCFAULT] <= wbyte[`FMC_CFG_FCFAULT];
                cfg[`FMC_CFG_FALERT]  <= wbyte[`FMC_CFG_FALERT];
                cfg[`FMC_CFG_POL]     <= wbyte[`FMC_CFG_POL];
                // a write of 1 wins over the end of a running test
                if (wbyte[`FMC_CFG_FWTEST]) begin
                    cfg[`FMC_CFG_FWTEST] <= 1'b1;
                end
            end
        end
    end

    // free-wheel test timer; a fresh launch restarts it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fw_cnt <= 32'h0;
        end else if (wr_hit && idx == `FMC_IDX_CFG && wbyte[`FMC_CFG_FWTEST]) begin
            fw_cnt <= 32'h0;
        end else if (cfg[`FMC_CFG_FWTEST] && !fw_done) begin
            fw_cnt <= fw_cnt + 32'h1;
        end else begin
            fw_cnt <= 32'h0;
        end
    end

    // fans-in-system; bit 1 is the install bit seen from both registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fans <= `FMC_RST_FANS;
        end else if (state == fmc_pkg::FMC_LOAD) begin
            fans[1] <= strap_s2[0];
        end else if (wr_hit && idx == `FMC_IDX_FANS) begin
            fans <= wbyte[1:0];
        end else if (wr_hit && idx == `FMC_IDX_CFG) begin
            fans[1] <= wbyte[`FMC_CFG_INSTALL];
        end
    end

    // pin_function_select; bit 7 has no storage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pinsel <= `FMC_RST_PINSEL;
        end else if (state == fmc_pkg::FMC_LOAD) begin
            pinsel[4:3] <= {2{~strap_s2[1]}};
            pinsel[6:5] <= {2{~strap_s2[2]}};
        end else if (wr_hit && idx == `FMC_IDX_PINSEL) begin
            pinsel <= wbyte[6:0];
        end
    end

    // per-fan force registers, two live bits each
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            alarm_force   <= `FMC_RST_FORCE;
            hotplug_force <= `FMC_RST_FORCE;
        end else if (wr_hit) begin
            if (idx == `FMC_IDX_ALARM) begin
                alarm_force <= wbyte[1:0];
            end
            if (idx == `FMC_IDX_HOTPLUG) begin
                hotplug_force <= wbyte[1:0];
            end
        end
    end

    // read mux; reserved bits and unmapped addresses read zero
    always_comb begin
        rd_value = 8'h00;
        case (idx)
            `FMC_IDX_CFG:     rd_value = {cfg, fans[1]};
            `FMC_IDX_FANS:    rd_value = {6'h00, fans};
            `FMC_IDX_PINSEL:  rd_value = {1'b0, pinsel};
            `FMC_IDX_ALARM:   rd_value = {6'h00, alarm_force};
            `FMC_IDX_HOTPLUG: rd_value = {6'h00, hotplug_force};
            default:          rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            av_readdata <= 32'h0;
        end else if (av_req.read && !ack && state == fmc_pkg::FMC_RUN) begin
            av_readdata <= {24'h0, rd_value};
        end
    end

    // mask gates only the sources; the force bit bypasses it
    assign alert_on = (~cfg[`FMC_CFG_MASK] & (|irq_source)) | cfg[`FMC_CFG_FALERT];

    // pin-facing outputs are registered, one cycle after their cause
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            alert_pin       <= 1'b1;
            cascade_fault_n <= 1'b1;
            ara_respond_en  <= 1'b0;
            monitor_run     <= 1'b0;
            fw_test_run     <= 1'b0;
            fan_force       <= '0;
            pin_select      <= `FMC_RST_PINSEL;
        end else begin
            alert_pin       <= alert_on ~^ cfg[`FMC_CFG_POL];
            cascade_fault_n <= ~(fault_active | cfg[`FMC_CFG_FCFAULT]);
            ara_respond_en  <= ~cfg[`FMC_CFG_ARA_DIS] & alert_on;
            monitor_run     <= cfg[`FMC_CFG_START] & ~cfg[`FMC_CFG_FWTEST];
            fw_test_run     <= cfg[`FMC_CFG_FWTEST];
            fan_force.alarm <= alarm_force | {2{~cfg[`FMC_CFG_START]}};
            fan_force.hotplug <= hotplug_force;
            pin_select      <= pinsel;
        end
    end

    mirror_bits_a: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_hit && idx == `FMC_IDX_FANS) |=> (fans[1] == $past(wbyte[1])))
        else $error("install bit does not follow fans register write");

    alert_masked_a: assert property (@(posedge clk) disable iff (!rst_b)
        (cfg[`FMC_CFG_MASK] && !cfg[`FMC_CFG_FALERT]) |=> (alert_pin == ~$past(cfg[`FMC_CFG_POL])))
        else $error("masked alert output asserted");

    ara_disable_a: assert property (@(posedge clk) disable iff (!rst_b)
        cfg[`FMC_CFG_ARA_DIS] |=> !ara_respond_en)
        else $error("alert response enabled while disabled");

    fw_pause_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(cfg[`FMC_CFG_FWTEST]) |=> (!monitor_run && fw_test_run))
        else $error("monitoring not paused during free-wheel test");

    fw_end_a: assert property (@(posedge clk) disable iff (!rst_b)
        (fw_done && !(wr_hit && idx == `FMC_IDX_CFG && wbyte[`FMC_CFG_FWTEST])) |=> !cfg[`FMC_CFG_FWTEST])
        else $error("free-wheel bit not cleared at test end");

    fw_len_a: assert property (@(posedge clk) disable iff (!rst_b)
        cfg[`FMC_CFG_FWTEST] |-> (fw_cnt < FW_TEST_CYCLES))
        else $error("free-wheel timer overran");

    idle_alarm_a: assert property (@(posedge clk) disable iff (!rst_b)
        !cfg[`FMC_CFG_START] |=> (fan_force.alarm == 2'h3))
        else $error("fans not at alarm speed while monitoring is off");

    strap_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state == fmc_pkg::FMC_LOAD) |=> (cfg[`FMC_CFG_START] == $past(strap_s2[0]) && fans[1] == $past(strap_s2[0])))
        else $error("strap not loaded into start and install bits");

    diode_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state == fmc_pkg::FMC_LOAD) |=> (pinsel[3] == ~$past(strap_s2[1]) && pinsel[6] == ~$past(strap_s2[2])))
        else $error("diode detect not loaded into pin select");

    cascade_fault_n_force_a: assert property (@(posedge clk) disable iff (!rst_b)
        cfg[`FMC_CFG_FCFAULT] |=> !cascade_fault_n)
        else $error("cascade fault not forced low");

    alert_force_a: assert property (@(posedge clk) disable iff (!rst_b)
        cfg[`FMC_CFG_FALERT] |=> (alert_pin == $past(cfg[`FMC_CFG_POL])))
        else $error("forced alert not at selected level");

    reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
        (ack && av_req.read && idx != `FMC_IDX_CFG) |-> (av_readdata[31:7] == 25'h0))
        else $error("reserved bits read nonzero");

    force_regs_a: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_hit && idx == `FMC_IDX_HOTPLUG) |=> ##1 (fan_force.hotplug == $past(wbyte[1:0], 2)))
        else $error("hot-plug force not applied");

    // bus side: a write lands once, a refused write leaves the force, pin-select and fans registers alone
    write_lands_a: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_hit && idx == `FMC_IDX_ALARM) |=> (alarm_force == $past(wbyte[1:0])))
        else $error("alarm force write did not land");

    single_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
        ack |=> !ack)
        else $error("one access answered twice");

    ignore_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        (ack && av_req.write && !av_req.byteenable[0]) |=>
            ($stable(alarm_force) && $stable(hotplug_force) && $stable(pinsel) && $stable(fans)))
        else $error("write without low byte lane changed a register");

    bus_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state != fmc_pkg::FMC_RUN) |-> av_waitrequest)
        else $error("bus answered before straps were loaded");

    fans_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_hit && idx == `FMC_IDX_CFG) |=> (fans[1] == $past(wbyte[`FMC_CFG_INSTALL])))
        else $error("fans bit 1 does not follow config install write");

    read_mirror_a: assert property (@(posedge clk) disable iff (!rst_b)
        (ack && av_req.read && idx == `FMC_IDX_CFG) |-> (av_readdata[0] == fans[1]))
        else $error("config install bit reads unlike fans bit 1");

    alarm_apply_a: assert property (@(posedge clk) disable iff (!rst_b)
        (alarm_force != 2'h0) |=> ((fan_force.alarm & $past(alarm_force)) == $past(alarm_force)))
        else $error("alarm force not applied to fan");

    alert_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!cfg[`FMC_CFG_FALERT] && (cfg[`FMC_CFG_MASK] || irq_source == '0)) |=>
            (alert_pin == !$past(cfg[`FMC_CFG_POL])))
        else $error("idle alert level not opposite to polarity");

    ara_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!cfg[`FMC_CFG_ARA_DIS] && cfg[`FMC_CFG_FALERT]) |=> ara_respond_en)
        else $error("alert response not enabled while alert asserted");

    fw_start_a: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_hit && idx == `FMC_IDX_CFG && wbyte[`FMC_CFG_FWTEST]) |=> (cfg[`FMC_CFG_FWTEST] && fw_cnt == 32'h0))
        else $error("free-wheel test not launched by write");

    fw_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        cfg[`FMC_CFG_FWTEST] |=> (!monitor_run && fw_test_run))
        else $error("monitoring ran during free-wheel test");

    run_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
        (cfg[`FMC_CFG_START] && !cfg[`FMC_CFG_FWTEST]) |=> monitor_run)
        else $error("monitoring not running after start");

    cascade_fault_n_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!cfg[`FMC_CFG_FCFAULT] && !fault_active) |=> cascade_fault_n)
        else $error("cascade fault low with no cause");

    diode_pair_a: assert property (@(posedge clk) disable iff (!rst_b)
        (state == fmc_pkg::FMC_LOAD) |=> (pinsel[4] == ~$past(strap_s2[1]) && pinsel[5] == ~$past(strap_s2[2])))
        else $error("diode detect not loaded into both pin select bits");

    pinsel_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_hit && idx == `FMC_IDX_PINSEL) |=> (pinsel == $past(wbyte[6:0])))
        else $error("pin select write did not land");

    pin_copy_a: assert property (@(posedge clk) disable iff (!rst_b)
        1'b1 |=> (pin_select == $past(pinsel)))
        else $error("pin select output lags its register");

endmodule

// file: sim/fmc_fan_diode_model.sv
`timescale 1ns/1ns
module fmc_fan_diode_model (
    input  wire logic fan_two_fitted,
    input  wire logic diode_one_fitted,
    input  wire logic diode_two_fitted,
    output logic      install_strap_pin,
    output logic      remote_diode_one,
    output logic      remote_diode_two
);
    // plain levels: the straps never move outside reset, so no glitching is modelled
    assign install_strap_pin = fan_two_fitted;
    assign remote_diode_one  = diode_one_fitted;
    assign remote_diode_two  = diode_two_fitted;
endmodule

// file: sim/fan_monitor_config_regs_tb.sv
`timescale 1ns/1ns
`include "fmc_params.svh"
module fan_monitor_config_regs_tb;
    localparam int unsigned FW_CYC = 20;
    logic                 clk = 1'b0;
    logic                 rst_b = 1'b0;
    fmc_pkg::fmc_av_req_t av_req = '0;
    logic [31:0]          av_readdata;
    logic                 av_waitrequest;
    logic                 strap, d_one, d_two, f2, dd1, dd2;
    logic [3:0]           irq_source = 4'h0;
    logic                 fault_active = 1'b0;
    logic                 alert_pin, cascade_fault_n, ara_respond_en, monitor_run, fw_test_run;
    fmc_pkg::fmc_fan_t    fan_force;
    logic [6:0]           pin_select;
    logic [3:0]           be = 4'h1;
    int                   fails = 0;
    int                   checked = 0;

    always #5 clk = ~clk;

    fmc_fan_diode_model fmc_fan_diode_model_i (.fan_two_fitted(f2), .diode_one_fitted(dd1),
        .diode_two_fitted(dd2), .install_strap_pin(strap), .remote_diode_one(d_one), .remote_diode_two(d_two));

    fmc_config_regs #(.N_IRQ(4), .FW_TEST_CYCLES(FW_CYC)) fmc_config_regs_i (.clk(clk), .rst_b(rst_b),
        .av_req(av_req), .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
        .install_strap_pin(strap), .remote_diode_one(d_one), .remote_diode_two(d_two),
        .irq_source(irq_source), .fault_active(fault_active), .alert_pin(alert_pin),
        .cascade_fault_n(cascade_fault_n), .ara_respond_en(ara_respond_en), .monitor_run(monitor_run),
        .fw_test_run(fw_test_run), .fan_force(fan_force), .pin_select(pin_select));

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // holds the request until waitrequest is sampled low at a rising edge
    task automatic access(input logic wr, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        av_req.read <= ~wr;
        av_req.write <= wr;
        av_req.address <= {idx, 2'b00};
        av_req.writedata <= wd;
        av_req.byteenable <= be;
        do begin
            @(posedge clk);
            n++;
        end while (av_waitrequest !== 1'b0 && n < 50);
        if (av_waitrequest !== 1'b0) begin
            fails++;
            $display("unexpected at %0t: no bus answer", $time);
        end
        rd = av_readdata;
        av_req.read <= 1'b0;
        av_req.write <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] unused;
        access(1'b1, idx, {24'h0, d}, unused);
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        logic [31:0] got;
        access(1'b0, idx, 32'h0, got);
        check(got, {24'h0, exp}, "register read");
    endtask

    // outputs are registered one edge behind the register itself
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic pins(input logic [6:0] ps, input logic [3:0] ff, input logic [4:0] misc);
        check({25'h0, pin_select}, {25'h0, ps}, "pin select");
        check({28'h0, fan_force}, {28'h0, ff}, "fan force");
        check({27'h0, alert_pin, cascade_fault_n, ara_respond_en, monitor_run, fw_test_run},
              {27'h0, misc}, "alert cascade_fault_n ara run fwtest");
    endtask

    task automatic do_reset(input logic a, input logic b, input logic c);
        @(posedge clk);
        rst_b <= 1'b0;
        f2 <= a;
        dd1 <= b;
        dd2 <= c;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
    endtask

    initial begin
        #100000;
        fails++;
        give_verdict();
    end

    initial begin
        f2 = 1'b1;
        dd1 = 1'b1;
        dd2 = 1'b0;
        do_reset(1'b1, 1'b1, 1'b0);
        rd_chk(`FMC_IDX_CFG, 8'h11);
        rd_chk(`FMC_IDX_FANS, 8'h03);
        rd_chk(`FMC_IDX_PINSEL, 8'h67);
        rd_chk(`FMC_IDX_ALARM, 8'h00);
        rd_chk(`FMC_IDX_HOTPLUG, 8'h00);
        rd_chk(6'h02, 8'h00);
        settle();
        pins(7'h67, 4'h0, 5'b11010);
        wr(`FMC_IDX_FANS, 8'h01);
        rd_chk(`FMC_IDX_CFG, 8'h10);
        wr(`FMC_IDX_CFG, 8'h01);
        rd_chk(`FMC_IDX_FANS, 8'h03);
        settle();
        pins(7'h67, 4'hc, 5'b11000);
        wr(`FMC_IDX_CFG, 8'h10);
        wr(`FMC_IDX_PINSEL, 8'hff);
        rd_chk(`FMC_IDX_PINSEL, 8'h7f);
        wr(`FMC_IDX_PINSEL, 8'h80);
        rd_chk(`FMC_IDX_PINSEL, 8'h00);
        wr(`FMC_IDX_ALARM, 8'hfe);
        wr(`FMC_IDX_HOTPLUG, 8'hfd);
        wr(6'h02, 8'hff);
        be = 4'h0;
        wr(`FMC_IDX_ALARM, 8'h03);
        be = 4'h1;
        rd_chk(`FMC_IDX_ALARM, 8'h02);
        rd_chk(`FMC_IDX_HOTPLUG, 8'h01);
        rd_chk(6'h02, 8'h00);
        settle();
        pins(7'h00, 4'h9, 5'b11010);
        @(posedge clk);
        irq_source <= 4'h4;
        settle();
        pins(7'h00, 4'h9, 5'b01110);
        wr(`FMC_IDX_CFG, 8'h12);
        settle();
        pins(7'h00, 4'h9, 5'b11010);
        wr(`FMC_IDX_CFG, 8'h52);
        settle();
        pins(7'h00, 4'h9, 5'b01110);
        wr(`FMC_IDX_CFG, 8'hd6);
        settle();
        pins(7'h00, 4'h9, 5'b11010);
        @(posedge clk);
        irq_source <= 4'h0;
        wr(`FMC_IDX_CFG, 8'hb0);
        settle();
        pins(7'h00, 4'h9, 5'b00010);
        @(posedge clk);
        fault_active <= 1'b1;
        wr(`FMC_IDX_CFG, 8'h10);
        settle();
        pins(7'h00, 4'h9, 5'b10010);
        @(posedge clk);
        fault_active <= 1'b0;
        wr(`FMC_IDX_CFG, 8'h18);
        settle();
        pins(7'h00, 4'h9, 5'b11001);
        rd_chk(`FMC_IDX_CFG, 8'h18);
        repeat (FW_CYC + 5) @(posedge clk);
        rd_chk(`FMC_IDX_CFG, 8'h10);
        settle();
        pins(7'h00, 4'h9, 5'b11010);
        do_reset(1'b0, 1'b0, 1'b1);
        rd_chk(`FMC_IDX_CFG, 8'h00);
        rd_chk(`FMC_IDX_FANS, 8'h01);
        rd_chk(`FMC_IDX_PINSEL, 8'h1f);
        rd_chk(`FMC_IDX_ALARM, 8'h00);
        settle();
        pins(7'h1f, 4'hc, 5'b11000);
        give_verdict();
    end
endmodule
